// ### inc/arf_pkg.sv
/*
 * Shared constants for the aspect-ratio FIFO: register map, reset values,
 * configuration codes and default geometry.
 * Assumes one 25 MHz clock and a synchronous active-low reset.
 */
// ==========================================================================

package arf_pkg;

    // ======================================================================
    // Default geometry
    localparam int unsigned WR_W_DEF = 8;
    localparam int unsigned RD_W_DEF = 8;
    localparam int unsigned WR_DEPTH_DEF = 16;
    localparam int unsigned MACRO_DEPTH_DEF = 512;
    localparam int unsigned LA_EXTRA_WORDS = 2;
    localparam int unsigned MAX_RATIO = 8;

    // ======================================================================
    // Register map, byte offsets
    localparam logic [7:0] REG_THRESH = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_WCOUNT = 8'h08;
    localparam logic [7:0] REG_RCOUNT = 8'h0C;

    // ======================================================================
    // Reset values and status bit positions
    localparam logic [15:0] THRESH_RST = 16'h0002;
    localparam int unsigned ST_FULL = 0;
    localparam int unsigned ST_EMPTY = 1;
    localparam int unsigned ST_THR_LOW = 2;
    localparam int unsigned ST_VALID = 3;

    // ======================================================================
    // Output register choice and memory kind codes
    localparam logic [1:0] OREG_NONE = 2'h0;
    localparam logic [1:0] OREG_EMBED = 2'h1;
    localparam logic [1:0] OREG_FABRIC = 2'h2;
    localparam logic [1:0] MEM_BLOCK = 2'h0;
    localparam logic [1:0] MEM_MACRO_OLD = 2'h1;
    localparam logic [1:0] MEM_MACRO_NEW = 2'h2;

endpackage

// ### design/arf_levels.sv
/*
 * Fill-level arithmetic: whole-word full and empty, counts in port units,
 * threshold-low compare.
 * Assumes the stored amount is kept in units of the narrower port width.
 */
`timescale 1ns/10ps

module arf_levels #(
    parameter int unsigned CW = 6,
    parameter int unsigned WU = 1,
    parameter int unsigned RU = 1,
    parameter int unsigned CAP_U = 16
) (
    input wire logic [CW-1:0] units_i,
    input wire logic [15:0] thresh_i,
    output logic full_o,
    output logic empty_o,
    output logic [CW-1:0] wr_count_o,
    output logic [CW-1:0] rd_count_o,
    output logic thr_low_o
);

    // ======================================================================
    // Flags
    wire [CW:0] after_wr = {1'b0, units_i} + (CW+1)'(WU);
    wire [CW:0] round_up = {1'b0, units_i} + (CW+1)'(WU - 1);

    // Full stays set until a whole write word fits again
    assign full_o = after_wr > (CW+1)'(CAP_U);
    // Empty stays set while less than a whole read word is held
    assign empty_o = units_i < CW'(RU);

    // ======================================================================
    // Counts, each in its own port's words
    // Rounding up keeps the write side pessimistic about free room
    assign wr_count_o = CW'(round_up / (CW+1)'(WU));
    assign rd_count_o = units_i / CW'(RU);
    // Exact compare, so no departure even while empty
    assign thr_low_o = 32'(rd_count_o) <= 32'(thresh_i);

endmodule

// ### design/arf_out_pipe.sv
/*
 * Optional output pipeline stage for read data and valid.
 * Assumes the stage, when present, is enabled on every clock.
 */
`timescale 1ns/10ps

module arf_out_pipe #(
    parameter int unsigned W = 8,
    parameter bit EN = 1'b0,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] data_i,
    input wire logic valid_i,
    output logic [W-1:0] data_o,
    output logic valid_o
);

    // ======================================================================
    // Stage or bypass
    if (EN) begin : g_reg
        // Always enabled: no hold, so it costs exactly one cycle
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                data_o <= RST_VAL;
                valid_o <= 1'b0;
            end else begin
                data_o <= data_i;
                valid_o <= valid_i;
            end
        end
    end else begin : g_thru
        assign data_o = data_i;
        assign valid_o = valid_i;
    end

endmodule

// ### design/arf_top.sv
/*
 * Common-clock FIFO with independent write and read widths, power-of-two
 * ratio up to eight either way, optional lookahead read and output stage,
 * and a small register port for threshold and status.
 * Assumes both users sit on core_clk_i and every input is synchronous.
 */
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

module arf_top #(
    parameter int unsigned WR_W = arf_pkg::WR_W_DEF,
    parameter int unsigned RD_W = arf_pkg::RD_W_DEF,
    parameter int unsigned WR_DEPTH = arf_pkg::WR_DEPTH_DEF,
    parameter bit LOOKAHEAD_READ_MODE = 1'b0,
    parameter logic [1:0] OUT_SEL = arf_pkg::OREG_NONE,
    parameter logic [1:0] MEM_KIND = arf_pkg::MEM_BLOCK,
    parameter int unsigned MACRO_DEPTH = arf_pkg::MACRO_DEPTH_DEF,
    parameter logic [RD_W-1:0] DOUT_RST_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Write side
    input wire logic wr_en_i,
    input wire logic [WR_W-1:0] wr_data_i,
    output logic full_o,
    output logic [$clog2(WR_DEPTH*WR_W+2*RD_W+1)-1:0] wr_count_o,
    // Read side
    input wire logic rd_en_i,
    output logic [RD_W-1:0] rd_data_o,
    output logic valid_o,
    output logic empty_o,
    output logic [$clog2(WR_DEPTH*WR_W+2*RD_W+1)-1:0] rd_count_o,
    output logic thr_low_o,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);

    // ======================================================================
    // Geometry, all in units of the narrower port
    localparam int unsigned MIN_W = (WR_W < RD_W) ? WR_W : RD_W;
    localparam int unsigned WU = WR_W / MIN_W;
    localparam int unsigned RU = RD_W / MIN_W;
    // Read depth follows from write depth and both widths
    localparam int unsigned DEPTH_U = WR_DEPTH * WU;
    localparam int unsigned RD_DEPTH = DEPTH_U / RU;
    // Lookahead holds two more read words of storage
    localparam int unsigned CAP_U = DEPTH_U +
        (LOOKAHEAD_READ_MODE ? arf_pkg::LA_EXTRA_WORDS * RU : 0);
    localparam int unsigned PW = $clog2(CAP_U);
    localparam int unsigned CW = $clog2(WR_DEPTH*WR_W+2*RD_W+1);
    localparam bit RATIO_OK = (WR_W % MIN_W == 0) && (RD_W % MIN_W == 0) &&
        (WU == 1 || WU == 2 || WU == 4 || WU == 8) &&
        (RU == 1 || RU == 2 || RU == 4 || RU == 8);
    // Old macro embeds its stage only when one macro covers the depth
    localparam bit ONE_MACRO = WR_DEPTH <= MACRO_DEPTH;
    // Stage present: standard with any register, or lookahead with embedded register on one old macro
    localparam bit PIPE_EN = LOOKAHEAD_READ_MODE ?
        (MEM_KIND == arf_pkg::MEM_MACRO_OLD &&
         OUT_SEL == arf_pkg::OREG_EMBED && ONE_MACRO) :
        (OUT_SEL != arf_pkg::OREG_NONE);

    // ======================================================================
    // Storage and state
    logic [MIN_W-1:0] mem [CAP_U];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] units;
    logic [RD_W-1:0] data_q;
    logic valid_q;
    logic [15:0] thresh;
    logic [31:0] rdata;

    // ======================================================================
    // Pointer step with wrap, capacity need not be a power of two
    function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p,
                                              input int unsigned k);
        int unsigned s;
        s = int'(p) + k;
        if (s >= CAP_U) begin
            s = s - CAP_U;
        end
        return PW'(s);
    endfunction

    // Distance from the write pointer to a slot, going forward
    function automatic int unsigned ptr_dist(input logic [PW-1:0] p,
                                             input logic [PW-1:0] w);
        int unsigned d;
        d = (p >= w) ? int'(p) - int'(w) : int'(p) + CAP_U - int'(w);
        return d;
    endfunction

    // Gather a read word, earliest unit into the top bits
    // With bypass, units written in this cycle come from the write bus
    function automatic logic [RD_W-1:0] gather(input logic [PW-1:0] base,
                                               input logic byp,
                                               input logic wr_now);
        logic [RD_W-1:0] w;
        logic [PW-1:0] p;
        int unsigned d;
        w = '0;
        for (int unsigned k = 0; k < RU; k++) begin
            p = ptr_add(base, k);
            d = ptr_dist(p, wptr);
            if (byp && wr_now && d < WU) begin
                w[RD_W-1-k*MIN_W -: MIN_W] = wr_data_i[WR_W-1-d*MIN_W -: MIN_W];
            end else begin
                w[RD_W-1-k*MIN_W -: MIN_W] = mem[p];
            end
        end
        return w;
    endfunction

    // ======================================================================
    // Levels and flags from the stored unit count
    logic full;
    logic empty;
    logic [CW-1:0] wr_count;
    logic [CW-1:0] rd_count;
    logic thr_low;

    arf_levels #(
        .CW(CW),
        .WU(WU),
        .RU(RU),
        .CAP_U(CAP_U)
    ) u_levels (
        .units_i(units),
        .thresh_i(thresh),
        .full_o(full),
        .empty_o(empty),
        .wr_count_o(wr_count),
        .rd_count_o(rd_count),
        .thr_low_o(thr_low)
    );

    // ======================================================================
    // Request acceptance and next state
    // Requests against a set flag fall away here
    wire wr_ok = wr_en_i && !full;
    wire rd_ok = rd_en_i && !empty;
    wire [CW-1:0] wr_step = wr_ok ? CW'(WU) : '0;
    wire [CW-1:0] rd_step = rd_ok ? CW'(RU) : '0;
    wire [CW-1:0] next_units = CW'(units + wr_step - rd_step);
    wire [PW-1:0] next_wptr = wr_ok ? ptr_add(wptr, WU) : wptr;
    wire [PW-1:0] next_rptr = rd_ok ? ptr_add(rptr, RU) : rptr;
    wire next_empty = next_units < CW'(RU);

    // Word for the next data register value
    // Lookahead fetches the new head, standard fetches on a read only
    wire [RD_W-1:0] la_word = gather(next_rptr, 1'b1, wr_ok);
    wire [RD_W-1:0] std_word = gather(rptr, 1'b0, 1'b0);
    wire [RD_W-1:0] next_data = LOOKAHEAD_READ_MODE ? la_word :
                                (rd_ok ? std_word : data_q);
    wire next_valid = LOOKAHEAD_READ_MODE ? !next_empty : rd_ok;

    // ======================================================================
    // Memory write, one write word spread over its units
    always_ff @(posedge core_clk_i) begin
        if (wr_ok) begin
            for (int unsigned k = 0; k < WU; k++) begin
                mem[ptr_add(wptr, k)] <= wr_data_i[WR_W-1-k*MIN_W -: MIN_W];
            end
        end
    end

    // ======================================================================
    // Pointers and stored amount
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wptr <= '0;
            rptr <= '0;
            units <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            units <= next_units;
        end
    end

    // ======================================================================
    // Read data and valid ahead of the optional stage
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            data_q <= DOUT_RST_VAL;
            valid_q <= 1'b0;
        end else begin
            data_q <= next_data;
            valid_q <= next_valid;
        end
    end

    // ======================================================================
    // Output stage, one cycle on data and valid only
    arf_out_pipe #(
        .W(RD_W),
        .EN(PIPE_EN),
        .RST_VAL(DOUT_RST_VAL)
    ) u_out_pipe (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .data_i(data_q),
        .valid_i(valid_q),
        .data_o(rd_data_o),
        .valid_o(valid_o)
    );

    // ======================================================================
    // Register port
    // Threshold write steers the flag; reads show live state
    wire [31:0] status_word = {28'h0000000, valid_o, thr_low, empty, full};
    wire [31:0] read_mux =
        (reg_addr_i == arf_pkg::REG_THRESH) ? {16'h0000, thresh} :
        (reg_addr_i == arf_pkg::REG_STATUS) ? status_word :
        (reg_addr_i == arf_pkg::REG_WCOUNT) ? 32'(wr_count) :
        (reg_addr_i == arf_pkg::REG_RCOUNT) ? 32'(rd_count) :
        32'h00000000;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            thresh <= arf_pkg::THRESH_RST;
        end else if (reg_wr_i && reg_addr_i == arf_pkg::REG_THRESH) begin
            thresh <= reg_wdata_i[15:0];
        end
    end

    // Read data stand one cycle, zero otherwise
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata <= '0;
        end else begin
            rdata <= reg_rd_i ? read_mux : 32'h00000000;
        end
    end

    // ======================================================================
    // Port outputs
    assign full_o = full;
    assign empty_o = empty;
    assign wr_count_o = wr_count;
    assign rd_count_o = rd_count;
    assign thr_low_o = thr_low;
    assign reg_rdata_o = rdata;

    // ======================================================================
    // Checks
    ratio_legal_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        RATIO_OK && RD_DEPTH * RU == DEPTH_U)
        else $error("Port width ratio outside the supported set");

    fill_step_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_ok && !rd_ok |=> units == CW'($past(units) + WU))
        else $error("Accepted write did not add one write word");

    drain_step_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        rd_ok && !wr_ok |=> units == CW'($past(units) - RU))
        else $error("Accepted read did not remove one read word");

    refuse_full_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_en_i && full && !rd_en_i |=> $stable(wptr) && $stable(units))
        else $error("Write into full changed state");

    whole_word_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !full |-> 32'(units) + WU <= CAP_U)
        else $error("Full cleared without room for a whole word");

    msb_first_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        wr_ok |=> mem[$past(wptr)] == $past(wr_data_i[WR_W-1 -: MIN_W]))
        else $error("Earliest unit not taken from the top bits");

    thr_flag_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        32'(rd_count) <= 32'(thresh) |-> thr_low)
        else $error("Threshold-low missing at or below level");

    std_valid_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !LOOKAHEAD_READ_MODE && rd_ok |=>
            (valid_q && (PIPE_EN || valid_o)) ##1 (!PIPE_EN || valid_o))
        else $error("Read valid not seen at the expected cycle");

    la_present_a: assert property (
        @(posedge core_clk_i) disable iff (!rst_n_i)
        LOOKAHEAD_READ_MODE |-> valid_q == !empty)
        else $error("Lookahead word not presented while data held");

endmodule

// ### testbench/arf_writer_model.sv
/*
 * Producer model standing on the write side of the aspect-ratio FIFO.
 * Assumes one common clock, synchronous active-low reset, and a bench
 * that asks for a write by raising req_i for one cycle.
 */
`timescale 1ns/10ps

module arf_writer_model #(
    parameter int unsigned W = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic force_i,
    input wire logic [W-1:0] data_i,
    input wire logic full_i,
    output logic wr_en_o,
    output logic [W-1:0] wr_data_o
);
    // ======================================================================
    // Write request, gated by the full flag
    // force_i lets a scenario push into a full store on purpose.
    // Idle data toggles every cycle so a stale word is never mistaken.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wr_en_o <= 1'b0;
            wr_data_o <= '0;
        end else begin
            wr_en_o <= req_i & (~full_i | force_i);
            wr_data_o <= req_i ? data_i : ~wr_data_o;
        end
    end
endmodule

// ### testbench/tb_aspect_ratio_fifo_output_stage.sv
/*
 * Self-checking bench: an 8-to-2 store with fabric output stage fed by the
 * producer model, a 2-to-8 lookahead store driven directly, one register bus.
 * Assumes the design package is compiled first and one 25 MHz clock.
 */
`timescale 1ns/10ps

`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: %s", $time, msg); end end

module tb_aspect_ratio_fifo_output_stage;
    // ======================================================================
    // Clock, reset, counters
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    int fail_count = 0;
    int checked = 0;
    always #20 core_clk_i = ~core_clk_i;

    // Wide-write store signals
    logic req = 1'b0;
    logic force_wr = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic a_wr_en;
    logic [7:0] a_wr_data;
    logic a_full, a_valid, a_empty, a_thr;
    logic a_rd_en = 1'b0;
    logic [5:0] a_wcnt, a_rcnt;
    logic [1:0] a_rdata;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    // Narrow-write store signals
    logic b_wr_en = 1'b0;
    logic b_rd_en = 1'b0;
    logic [1:0] b_wr_data = 2'h0;
    logic b_valid, b_empty;
    logic [7:0] b_rdata;
    logic [5:0] b_wcnt, b_rcnt;
    logic b_full, b_thr;
    logic [31:0] b_reg_rdata;

    // ======================================================================
    // Instances
    arf_writer_model writer (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .req_i(req), .force_i(force_wr), .data_i(req_data), .full_i(a_full),
        .wr_en_o(a_wr_en), .wr_data_o(a_wr_data));
    arf_top #(.RD_W(2), .WR_DEPTH(4), .OUT_SEL(arf_pkg::OREG_FABRIC)) dut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .wr_en_i(a_wr_en), .wr_data_i(a_wr_data), .full_o(a_full),
        .wr_count_o(a_wcnt), .rd_en_i(a_rd_en), .rd_data_o(a_rdata), .valid_o(a_valid),
        .empty_o(a_empty), .rd_count_o(a_rcnt), .thr_low_o(a_thr), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata));
    // Shares the register strobes, so threshold writes land in both stores
    arf_top #(.WR_W(2), .LOOKAHEAD_READ_MODE(1'b1)) dut_narrow (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .wr_en_i(b_wr_en), .wr_data_i(b_wr_data), .full_o(b_full),
        .wr_count_o(b_wcnt), .rd_en_i(b_rd_en), .rd_data_o(b_rdata), .valid_o(b_valid),
        .empty_o(b_empty), .rd_count_o(b_rcnt), .thr_low_o(b_thr), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(b_reg_rdata));

    // ======================================================================
    // Bus and port tasks
    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge core_clk_i);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge core_clk_i);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    // Write takes three edges: request, model launch, acceptance
    task automatic wr_a(input logic [7:0] d, input logic frc);
        @(posedge core_clk_i);
        req <= 1'b1;
        req_data <= d;
        force_wr <= frc;
        @(posedge core_clk_i);
        req <= 1'b0;
        force_wr <= 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask

    // Standard read behind the fabric stage: valid and slice two cycles after the pop
    task automatic rd_a(input logic [1:0] exp, input logic ok);
        @(posedge core_clk_i);
        a_rd_en <= 1'b1;
        @(posedge core_clk_i);
        a_rd_en <= 1'b0;
        #1;
        `CHK(a_valid, 1'b0, "valid held back by the stage")
        @(posedge core_clk_i);
        #1;
        `CHK(a_valid, ok, "read valid")
        if (ok) `CHK(a_rdata, exp, "read slice order")
    endtask

    task automatic wr_b(input logic [1:0] d);
        @(posedge core_clk_i);
        b_wr_en <= 1'b1;
        b_wr_data <= d;
        @(posedge core_clk_i);
        b_wr_en <= 1'b0;
        b_wr_data <= ~d;
        #1;
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_reset();
        `CHK(a_empty, 1'b1, "empty after reset")
        `CHK(a_wcnt, 6'h00, "write count after reset")
        `CHK(a_thr, 1'b1, "threshold flag after reset")
        `CHK(a_rdata, 2'h0, "read data reset value")
        reg_read(arf_pkg::REG_THRESH, rv);
        `CHK(rv, 32'h00000002, "threshold reset value")
        reg_read(arf_pkg::REG_STATUS, rv);
        `CHK(rv, 32'h00000006, "status after reset")
        reg_read(8'h10, rv);
        `CHK(rv, 32'h00000000, "unmapped read")
    endtask

    // One wide word gives four slices, top first
    task automatic t_wide_unpack();
        wr_a(8'hC7, 1'b0);
        `CHK(a_empty, 1'b0, "empty after one wide write")
        `CHK(a_rcnt, 6'h04, "read count in read words")
        `CHK(a_wcnt, 6'h01, "write count in write words")
        rd_a(2'h3, 1'b1);
        `CHK(a_wcnt, 6'h01, "write count keeps partial word")
        `CHK(a_rcnt, 6'h03, "read count after pop")
        rd_a(2'h0, 1'b1);
        rd_a(2'h1, 1'b1);
        `CHK(a_empty, 1'b0, "empty before fourth read")
        rd_a(2'h3, 1'b1);
        `CHK(a_empty, 1'b1, "empty after fourth read")
        rd_a(2'h0, 1'b0);
    endtask

    // Full holds until a whole write word is freed
    task automatic t_full();
        logic [7:0] words [3];
        words = '{8'h3C, 8'hF0, 8'h0F};
        wr_a(8'hA5, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr_a(words[i], 1'b0);
        end
        `CHK(a_full, 1'b1, "full after four writes")
        `CHK(a_wcnt, 6'h04, "write count at full")
        wr_a(8'hFF, 1'b1);
        `CHK(a_wcnt, 6'h04, "refused write left count")
        rd_a(2'h2, 1'b1);
        rd_a(2'h2, 1'b1);
        rd_a(2'h1, 1'b1);
        `CHK(a_full, 1'b1, "full after three reads")
        rd_a(2'h1, 1'b1);
        `CHK(a_full, 1'b0, "full clears after four reads")
        reg_write(arf_pkg::REG_THRESH, 32'h0000000C);
        `CHK(a_thr, 1'b1, "threshold flag at level")
        reg_write(arf_pkg::REG_THRESH, 32'h0000000B);
        `CHK(a_thr, 1'b0, "threshold flag above level")
        reg_read(arf_pkg::REG_STATUS, rv);
        `CHK(rv, 32'h00000000, "status mid fill")
        for (int i = 0; i < 3; i++) begin
            for (int k = 3; k >= 0; k--) begin
                rd_a(words[i][2*k+:2], 1'b1);
            end
        end
        `CHK(a_empty, 1'b1, "forced word was never stored")
    endtask

    // Four narrow writes pack top first; lookahead shows the word before any read
    task automatic t_narrow_pack();
        logic [1:0] units [4];
        units = '{2'h1, 2'h0, 2'h3, 2'h2};
        // Three times the depth quotient of four, single clock
        reg_write(arf_pkg::REG_THRESH, 32'h0000000C);
        for (int i = 0; i < 4; i++) begin
            `CHK(b_empty, 1'b1, "empty before whole word")
            wr_b(units[i]);
        end
        `CHK(b_empty, 1'b0, "empty clears after four writes")
        `CHK(b_rcnt, 6'h01, "read count one wide word")
        `CHK(b_wcnt, 6'h04, "write count four narrow words")
        `CHK(b_valid, 1'b1, "packed word shown before read")
        `CHK(b_rdata, 8'h4E, "packed word order")
        `CHK(b_thr, 1'b1, "narrow threshold flag")
        reg_read(arf_pkg::REG_STATUS, rv);
        `CHK(b_reg_rdata, 32'h0000000C, "narrow status word")
        @(posedge core_clk_i);
        b_rd_en <= 1'b1;
        @(posedge core_clk_i);
        b_rd_en <= 1'b0;
        #1;
        `CHK(b_valid, 1'b0, "shown word taken")
        `CHK(b_empty, 1'b1, "empty after single read")
        // Plain depth is 16 units; lookahead adds two read words of four
        for (int i = 0; i < 24; i++) begin
            if (i == 16) `CHK(b_full, 1'b0, "room beyond plain depth")
            wr_b(2'(i));
        end
        `CHK(b_full, 1'b1, "full at lookahead capacity")
        `CHK(b_rcnt, 6'h06, "read count at capacity")
        `CHK(b_rdata, 8'h1B, "head word after wrap")
    endtask

    // ======================================================================
    // Verdict, main sequence, watchdog
    task automatic results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        t_reset();
        t_wide_unpack();
        t_full();
        t_narrow_pack();
        results();
    end

    // Whole run needs about 170 cycles; allow over twenty times that
    initial begin
        #160000;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule
